// ==== common/ext_irq_map.svh ====
/*
  Register offsets, field positions, reset values and vector numbers
  of the external interrupt front end.
  Assumes a plain 3-bit address, 8-bit data register port.
*/
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define ADDR_W            3
`define DATA_W            8
`define LINES             8
`define KEYS              16
`define VEC_W             6

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFF_SENSE_SELECT  3'h0
`define OFF_LINE_ENABLE   3'h1
`define OFF_KEY_MASK_LOW  3'h2
`define OFF_KEY_MASK_HIGH 3'h3
`define OFF_NMI_CTRL      3'h4
`define OFF_PENDING       3'h5

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define BIT_NMI_POLARITY  0
`define BIT_NMI_PENDING   1
`define RST_SENSE_SELECT  8'h00
`define RST_LINE_ENABLE   8'h00
`define RST_KEY_MASK_LOW  8'hBF
`define RST_KEY_MASK_HIGH 8'hFF
`define RST_NMI_POLARITY  1'b0
`define KEY_LINE          6
`define WAKE_LINES        8'h47

// ---------------------------------------------------------------
// Vector numbers
// ---------------------------------------------------------------
`define VEC_NMI           6'h03
`define VEC_LINE0         6'h04

`endif

// ==== common/ext_irq_pkg.sv ====
/*
  Types shared by the external interrupt front end.
  Assumes ext_irq_map.svh is on the include path.
*/
`include "ext_irq_map.svh"

package ext_irq_pkg;
  typedef logic [`ADDR_W-1:0] reg_addr_t;
  typedef logic [`DATA_W-1:0] reg_data_t;
  typedef logic [`LINES-1:0]  line_vec_t;
  typedef logic [`KEYS-1:0]   key_vec_t;
  typedef logic [`VEC_W-1:0]  vector_t;
endpackage

// ==== common/pin_sync_if.sv ====
/*
  Carrier between the pin synchroniser and the interrupt core.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/10ps

interface pin_sync_if #(parameter int W = 25);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport syncer (input raw, output level);
  modport user   (output raw, input level);
endinterface

// ==== hw/pin_sync.sv ====
/*
  Two-flop synchroniser bank for asynchronous pin inputs.
  Assumes pins idle high (active-low sources), so reset loads ones.
*/
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 25
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins in, synchronised levels out
  pin_sync_if.syncer p
);
  logic [W-1:0] meta_r;
  logic [W-1:0] level_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r  <= '1;
      level_r <= '1;
    end else begin
      meta_r  <= p.raw;
      level_r <= meta_r;
    end
  end

  assign p.level = level_r;
endmodule

// ==== hw/ext_irq_intc.sv ====
/*
  External interrupt front end: eight maskable request lines with
  level or falling-edge sense, key-sense merge onto line 6, an
  edge-selectable nonmaskable input, priority and vector to the CPU.
  Assumes: pins are asynchronous and active low; the CPU supplies its
  interrupt mask bit and pulses cpu_ack for the presented vector.
*/
// Operation
// [RL1] Sense bit: 0 low level, 1 falling edge
// [RL2] Per-line enable, resets to zero
// [RL3] Latched edge request survives enable clear
// [RL4] Disabled pending edge still served when unmasked
// [RL5] Mask, level sense, disabled: pending cleared
// [RL6] Software masks, disables, toggles sense to discard
// [RL7] Sixteen key masks, 0 enables input
// [RL8] Key masks reset disabled except low bit 6
// [RL9] Unmasked keys ORed into line 6
// [RL10] Nonmaskable request ignores CPU mask
// [RL11] Nonmaskable vector 3, sets CPU mask
// [RL12] Lines 0..7 vectors 4..11, 0 highest
// [RL13] Maskable acceptance sets CPU mask
// [RL14] CPU mask blocks all maskable lines
// [RL15] Detection uses pin level, any direction
// [RL16] Wake only from nonmaskable, 0, 1, 2, 6
// [RL17] Polarity bit: 0 falling, 1 rising
// [RL18] Masked: only nonmaskable forwarded, others wait
// [RL19] Synchronise pins, detect edges from samples
`timescale 1ns/10ps
`include "ext_irq_map.svh"

module ext_irq_intc
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Register port
  input  wire reg_addr_t reg_addr,
  input  wire reg_data_t reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output reg_data_t      reg_rdata,
  // External pins, active low
  input  wire line_vec_t irq_pin_n,
  input  wire key_vec_t  key_sense_input_n,
  input  wire logic      nmi_pin_n,
  // CPU side
  input  wire logic      cpu_int_mask,
  input  wire logic      cpu_ack,
  output logic           irq_req,
  output vector_t        irq_vector,
  output logic           cpu_mask_set,
  output logic           wake_req
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  line_vec_t irq_sense_select_r;
  line_vec_t irq_line_enable_r;
  reg_data_t key_sense_mask_low_r;
  reg_data_t key_sense_mask_high_r;
  logic      nonmaskable_edge_polarity_r;
  reg_data_t rdata_r;
  line_vec_t pend_r;
  line_vec_t line_low_prev_r;
  logic      nmi_prev_r;
  logic      nmi_pend_r;
  logic      req_r;
  vector_t   vector_r;
  logic      mask_set_r;
  logic      wake_r;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  pin_sync_if #(.W(`LINES + `KEYS + 1)) pins ();

  // Pin level is used whatever the port direction is set to
  assign pins.raw = {nmi_pin_n, key_sense_input_n, irq_pin_n}; // RL15

  pin_sync #(.W(`LINES + `KEYS + 1)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .p       (pins)
  ); // RL19

  line_vec_t irq_low;
  key_vec_t  key_low;
  logic      nmi_lvl;
  key_vec_t  key_mask;
  logic      key_hit;
  line_vec_t line_low;
  line_vec_t line_fall;
  logic      nmi_edge;
  logic      served;

  assign irq_low  = ~pins.level[`LINES-1:0];
  assign key_low  = ~pins.level[`LINES +: `KEYS];
  assign nmi_lvl  = pins.level[`LINES + `KEYS];
  assign key_mask = {key_sense_mask_high_r, key_sense_mask_low_r}; // RL7
  // Mask bit 6 also gates the shared line-6 pin
  assign key_hit  = |(key_low & ~key_mask); // RL9

  always_comb begin
    line_low = irq_low;
    line_low[`KEY_LINE] = key_hit | // RL9
                          (irq_low[`KEY_LINE] & ~key_mask[`KEY_LINE]);
  end

  // Edges come from registered samples, never from the first stage
  assign line_fall = line_low & ~line_low_prev_r; // RL19
  assign nmi_edge  = nonmaskable_edge_polarity_r ? // RL17
                     (nmi_lvl & ~nmi_prev_r) : (~nmi_lvl & nmi_prev_r);
  assign served    = cpu_ack & req_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      line_low_prev_r <= '0;
      nmi_prev_r      <= 1'b1;
    end else begin
      line_low_prev_r <= line_low;
      nmi_prev_r      <= nmi_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_sense_select_r          <= `RST_SENSE_SELECT;
      irq_line_enable_r           <= `RST_LINE_ENABLE; // RL2
      key_sense_mask_low_r        <= `RST_KEY_MASK_LOW; // RL8
      key_sense_mask_high_r       <= `RST_KEY_MASK_HIGH; // RL8
      nonmaskable_edge_polarity_r <= `RST_NMI_POLARITY; // RL17
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OFF_SENSE_SELECT:  irq_sense_select_r    <= reg_wdata;
        `OFF_LINE_ENABLE:   irq_line_enable_r     <= reg_wdata;
        `OFF_KEY_MASK_LOW:  key_sense_mask_low_r  <= reg_wdata;
        `OFF_KEY_MASK_HIGH: key_sense_mask_high_r <= reg_wdata;
        `OFF_NMI_CTRL: begin
          nonmaskable_edge_polarity_r <= reg_wdata[`BIT_NMI_POLARITY];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads, data valid one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFF_SENSE_SELECT:  rdata_r <= irq_sense_select_r;
        `OFF_LINE_ENABLE:   rdata_r <= irq_line_enable_r;
        `OFF_KEY_MASK_LOW:  rdata_r <= key_sense_mask_low_r;
        `OFF_KEY_MASK_HIGH: rdata_r <= key_sense_mask_high_r;
        `OFF_NMI_CTRL: begin
          rdata_r <= 8'h00;
          rdata_r[`BIT_NMI_POLARITY] <= nonmaskable_edge_polarity_r;
          rdata_r[`BIT_NMI_PENDING]  <= nmi_pend_r;
        end
        `OFF_PENDING:       rdata_r <= pend_r;
        default:            rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Pending flags, one per line; a new request beats any clear
  // ---------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `LINES; n++) begin : g_line
      logic set_req;
      logic clr_req;
      // New requests need the enable; old ones do not
      assign set_req = irq_line_enable_r[n] & // RL2 RL3
                       (irq_sense_select_r[n] ? line_fall[n] // RL1
                                              : line_low[n]); // RL1
      // Level sense drops once the pin goes high again
      assign clr_req = (served && vector_r == `VEC_LINE0 + 6'(n)) |
                       (cpu_int_mask & ~irq_sense_select_r[n] & // RL5
                        ~irq_line_enable_r[n]) |
                       (~irq_sense_select_r[n] & ~line_low[n]);
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pend_r[n] <= 1'b0;
        end else if (set_req) begin
          pend_r[n] <= 1'b1;
        end else if (clr_req) begin
          pend_r[n] <= 1'b0; // RL3
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_r <= 1'b1; // RL10
    end else if (served && vector_r == `VEC_NMI) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Priority and vector to the CPU
  // ---------------------------------------------------------------
  line_vec_t fwd;
  vector_t   vec_nxt;
  logic      req_nxt;

  // Enable is not looked at here, so a stale edge still gets served
  assign fwd = cpu_int_mask ? '0 : pend_r; // RL4 RL14 RL18

  always_comb begin
    vec_nxt = vector_r;
    req_nxt = nmi_pend_r | (|fwd);
    for (int i = `LINES - 1; i >= 0; i--) begin
      if (fwd[i]) begin
        vec_nxt = `VEC_LINE0 + 6'(i); // RL12
      end
    end
    if (nmi_pend_r) begin
      vec_nxt = `VEC_NMI; // RL11
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_r    <= 1'b0;
      vector_r <= `VEC_NMI;
    end else begin
      req_r    <= req_nxt;
      vector_r <= vec_nxt;
    end
  end

  // Every accepted request masks further maskable ones
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_set_r <= 1'b0;
    end else begin
      mask_set_r <= served; // RL11 RL13
    end
  end

  // Wake ignores the CPU mask; only some sources may wake
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= nmi_pend_r | (|(pend_r & `WAKE_LINES)); // RL16
    end
  end

  assign reg_rdata    = rdata_r;
  assign irq_req      = req_r;
  assign irq_vector   = vector_r;
  assign cpu_mask_set = mask_set_r;
  assign wake_req     = wake_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_level_set;
    irq_line_enable_r[0] && !irq_sense_select_r[0] && line_low[0]
      |=> pend_r[0];
  endproperty
  a_level_set: assert property (p_level_set) // RL1
    else $error("level request not latched");

  property p_edge_set;
    irq_line_enable_r[1] && irq_sense_select_r[1] && line_fall[1]
      |=> pend_r[1];
  endproperty
  a_edge_set: assert property (p_edge_set) // RL1
    else $error("edge request not latched");

  property p_enable_gate;
    $rose(pend_r[2]) |-> $past(irq_line_enable_r[2]);
  endproperty
  a_enable_gate: assert property (p_enable_gate) // RL2
    else $error("pending set while line disabled");

  property p_edge_hold;
    pend_r[3] && irq_sense_select_r[3] &&
      !(served && vector_r == 6'h07) |=> pend_r[3];
  endproperty
  a_edge_hold: assert property (p_edge_hold) // RL3
    else $error("edge pending dropped before service");

  property p_stale_fwd;
    pend_r[2] && !irq_line_enable_r[2] && !cpu_int_mask && !nmi_pend_r &&
      !pend_r[1] && !pend_r[0] |=> irq_req && irq_vector == 6'h06;
  endproperty
  a_stale_fwd: assert property (p_stale_fwd) // RL4
    else $error("disabled pending edge not forwarded");

  property p_discard;
    pend_r[1] && cpu_int_mask && !irq_sense_select_r[1] &&
      !irq_line_enable_r[1] |=> !pend_r[1];
  endproperty
  a_discard: assert property (p_discard) // RL5
    else $error("pending not discarded");

  property p_key_merge;
    key_low[8] && !key_sense_mask_high_r[0] && irq_line_enable_r[6] &&
      !irq_sense_select_r[6] |=> pend_r[6];
  endproperty
  a_key_merge: assert property (p_key_merge) // RL9
    else $error("unmasked key did not raise line 6");

  sequence s_nmi_seen;
    nmi_edge ##1 (nmi_pend_r && !cpu_ack);
  endsequence
  property p_nmi_fwd;
    s_nmi_seen |=> irq_req && irq_vector == 6'h03;
  endproperty
  a_nmi_fwd: assert property (p_nmi_fwd) // RL10
    else $error("nonmaskable request not forwarded");

  property p_mask_set;
    cpu_ack && irq_req |=> cpu_mask_set ##1 !cpu_mask_set;
  endproperty
  a_mask_set: assert property (p_mask_set) // RL13
    else $error("acceptance did not set CPU mask");

  property p_priority;
    pend_r[0] && pend_r[5] && !cpu_int_mask && !nmi_pend_r
      |=> irq_vector == 6'h04;
  endproperty
  a_priority: assert property (p_priority) // RL12
    else $error("line 0 lost priority");

  property p_masked;
    cpu_int_mask && !nmi_pend_r |=> !irq_req;
  endproperty
  a_masked: assert property (p_masked) // RL14
    else $error("maskable request passed CPU mask");

  property p_wake;
    $rose(wake_req) |->
      $past(nmi_pend_r || pend_r[0] || pend_r[1] || pend_r[2] ||
            pend_r[6]);
  endproperty
  a_wake: assert property (p_wake) // RL16
    else $error("wake from a source that may not wake");
endmodule

// ==== tb/cpu_exc_model.sv ====
/*
  Behavioural CPU exception side facing the interrupt front end.
  Assumes it shares clk_sys and rstn with the front end.
*/
`timescale 1ns/10ps
`include "ext_irq_map.svh"

module cpu_exc_model
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rstn,
  // From the front end
  input  wire logic     irq_req,
  input  wire vector_t  irq_vector,
  input  wire logic     cpu_mask_set,
  // Bench control of the mask bit
  input  wire logic     mask_wr,
  input  wire logic     mask_val,
  // To the front end and bench
  output logic          cpu_int_mask,
  output logic          cpu_ack,
  output vector_t       taken_vec,
  output logic [7:0]    n_taken
);
  logic [2:0] gap_r;

  // Hardware setting of the mask wins over a software write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_int_mask <= 1'b0;
    end else if (cpu_mask_set) begin
      cpu_int_mask <= 1'b1;
    end else if (mask_wr) begin
      cpu_int_mask <= mask_val;
    end
  end

  // Long gap after an ack lets the new mask settle first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_ack   <= 1'b0;
      gap_r     <= 3'h0;
      taken_vec <= 6'h00;
      n_taken   <= 8'h00;
    end else begin
      cpu_ack <= 1'b0;
      if (gap_r != 3'h0) begin
        gap_r <= gap_r - 3'h1;
      end else if (irq_req &&
                   (!cpu_int_mask || irq_vector == `VEC_NMI)) begin
        cpu_ack   <= 1'b1;
        gap_r     <= 3'h6;
        taken_vec <= irq_vector;
        n_taken   <= n_taken + 8'h01;
      end
    end
  end
endmodule

// ==== tb/external_irq_keyscan_intc_tb.sv ====
/*
  Self-checking bench for the external interrupt front end.
  Assumes the CPU side is the cpu_exc_model partner.
*/
`timescale 1ns/10ps
`include "ext_irq_map.svh"

module external_irq_keyscan_intc_tb
  import ext_irq_pkg::*;
;
  logic      clk_sys = 1'b0;
  logic      rstn = 1'b0;
  reg_addr_t reg_addr = 3'h0;
  reg_data_t reg_wdata = 8'h00;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  reg_data_t reg_rdata;
  line_vec_t irq_n = 8'hFF;
  key_vec_t  key_n = 16'hFFFF;
  logic      nmi_n = 1'b1;
  logic      mask_wr = 1'b0;
  logic      mask_val = 1'b0;
  logic      cpu_int_mask, cpu_ack, irq_req, mask_set, wake_req;
  vector_t   irq_vector, taken_vec;
  logic [7:0] n_taken, n0;
  int        n_mismatch = 0;
  int        checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  ext_irq_intc dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pin_n(irq_n), .key_sense_input_n(key_n),
    .nmi_pin_n(nmi_n), .cpu_int_mask(cpu_int_mask), .cpu_ack(cpu_ack),
    .irq_req(irq_req), .irq_vector(irq_vector),
    .cpu_mask_set(mask_set), .wake_req(wake_req));

  cpu_exc_model cpu (.clk_sys(clk_sys), .rstn(rstn), .irq_req(irq_req),
    .irq_vector(irq_vector), .cpu_mask_set(mask_set), .mask_wr(mask_wr),
    .mask_val(mask_val), .cpu_int_mask(cpu_int_mask), .cpu_ack(cpu_ack),
    .taken_vec(taken_vec), .n_taken(n_taken));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input reg_addr_t a, input reg_data_t exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk_sys);
  endtask

  task automatic setm(input logic v);
    @(posedge clk_sys);
    mask_wr <= 1'b1;
    mask_val <= v;
    @(posedge clk_sys);
    mask_wr <= 1'b0;
  endtask

  task automatic taken(input vector_t v);
    int i;
    for (i = 0; i < 40 && n_taken == n0; i++) cyc(1);
    chk(n_taken, n0 + 8'h01);
    chk({2'b00, taken_vec}, {2'b00, v});
    n0 = n_taken;
  endtask

  // Pulse a pin low for six cycles, long enough to pass the synchroniser
  task automatic pulse(input int ln);
    @(posedge clk_sys);
    irq_n[ln] <= 1'b0;
    cyc(6);
    irq_n[ln] <= 1'b1;
    cyc(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(`OFF_SENSE_SELECT, 8'h00);
    rd(`OFF_LINE_ENABLE, 8'h00);
    rd(`OFF_KEY_MASK_LOW, 8'hBF);
    rd(`OFF_KEY_MASK_HIGH, 8'hFF);
    rd(`OFF_NMI_CTRL, 8'h00);
    rd(3'h6, 8'h00);
  endtask

  task automatic t_level();
    n0 = n_taken;
    wr(`OFF_LINE_ENABLE, 8'h08);
    irq_n[3] <= 1'b0;
    taken(6'h07);
    irq_n[3] <= 1'b1;
    cyc(6);
    chk({7'h0, cpu_int_mask}, 8'h01);
    wr(`OFF_LINE_ENABLE, 8'h00);
    setm(1'b0);
  endtask

  task automatic t_prio();
    setm(1'b1);
    wr(`OFF_SENSE_SELECT, 8'h21);
    wr(`OFF_LINE_ENABLE, 8'h21);
    irq_n <= 8'hDE;
    cyc(8);
    irq_n <= 8'hFF;
    chk({7'h0, irq_req}, 8'h00);
    rd(`OFF_PENDING, 8'h21);
    setm(1'b0);
    taken(6'h04);
    cyc(4);
    setm(1'b0);
    taken(6'h09);
    wr(`OFF_LINE_ENABLE, 8'h00);
  endtask

  task automatic t_edge_hold();
    wr(`OFF_SENSE_SELECT, 8'h04);
    wr(`OFF_LINE_ENABLE, 8'h04);
    pulse(2);
    wr(`OFF_LINE_ENABLE, 8'h00);
    pulse(2);
    rd(`OFF_PENDING, 8'h04);
    setm(1'b0);
    taken(6'h06);
    cyc(20);
    chk(n_taken, n0);
    wr(`OFF_LINE_ENABLE, 8'h04);
    pulse(2);
    wr(`OFF_LINE_ENABLE, 8'h00);
    wr(`OFF_SENSE_SELECT, 8'h00);
    rd(`OFF_PENDING, 8'h00);
    wr(`OFF_SENSE_SELECT, 8'h04);
  endtask

  task automatic t_keys();
    wr(`OFF_SENSE_SELECT, 8'h00);
    wr(`OFF_LINE_ENABLE, 8'h40);
    wr(`OFF_KEY_MASK_LOW, 8'hFF);
    wr(`OFF_KEY_MASK_HIGH, 8'hFE);
    key_n[9] <= 1'b0;
    irq_n[6] <= 1'b0;
    cyc(6);
    rd(`OFF_PENDING, 8'h00);
    key_n[8] <= 1'b0;
    cyc(6);
    rd(`OFF_PENDING, 8'h40);
    key_n <= 16'hFFFF;
    irq_n <= 8'hFF;
    wr(`OFF_LINE_ENABLE, 8'h00);
    rd(`OFF_PENDING, 8'h00);
  endtask

  task automatic t_nmi();
    nmi_n <= 1'b0;
    taken(`VEC_NMI);
    nmi_n <= 1'b1;
    cyc(20);
    chk(n_taken, n0);
    wr(`OFF_NMI_CTRL, 8'h01);
    rd(`OFF_NMI_CTRL, 8'h01);
    nmi_n <= 1'b0;
    cyc(20);
    chk(n_taken, n0);
    setm(1'b0);
    nmi_n <= 1'b1;
    taken(`VEC_NMI);
    cyc(2);
    chk({7'h0, cpu_int_mask}, 8'h01);
  endtask

  task automatic t_wake();
    wr(`OFF_SENSE_SELECT, 8'h0A);
    wr(`OFF_LINE_ENABLE, 8'h0A);
    pulse(3);
    chk({7'h0, wake_req}, 8'h00);
    pulse(1);
    chk({7'h0, wake_req}, 8'h01);
    irq_n[1] <= 1'b0;
    wr(`OFF_LINE_ENABLE, 8'h00);
    wr(`OFF_SENSE_SELECT, 8'h00);
    rd(`OFF_PENDING, 8'h00);
    irq_n[1] <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    cyc(3);
    rstn <= 1'b1;
    cyc(4);
    t_reset();
    t_level();
    t_prio();
    t_edge_hold();
    t_keys();
    t_nmi();
    t_wake();
    wrap_up();
  end

  // Whole run needs under 300 cycles
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule
